/* core/hrp_pkg.sv */
/*
  Package for the host register port: sizes, select codes and the
  carrier structs that group the host pins and the register-side signals.
  Assumes a single 250 MHz system clock and an active-low async reset.
*/
`default_nettype none

package hrp_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned NUM_LOC = 8;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] LOC_RESET = 8'h00;
  localparam logic [2:0] SEL_RESET = 3'h0;

  // Host-side pins sampled on every clock.
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [2:0] sel;
    logic [7:0] data;
  } hrp_host_in_type;

  // Register-side write event.
  typedef struct packed {
    logic stb;
    logic [2:0] sel;
    logic [7:0] data;
  } hrp_wr_type;

endpackage : hrp_pkg

`default_nettype wire

/* core/hrp_edge.sv */
/*
  Edge detector for one active-low strobe: reports falling and rising
  edges combinationally, in the cycle the input changes. Assumes the input is already
  synchronous to sys_clk_i.
*/
`default_nettype none

module hrp_edge (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Strobe
  input wire logic strobe_n_i,
  output logic fall_o,
  output logic rise_o
);

  logic prev_q;

  // Strobes idle high, so the history starts high.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= strobe_n_i;
    end
  end

  assign fall_o = prev_q & ~strobe_n_i;
  assign rise_o = ~prev_q & strobe_n_i;

endmodule : hrp_edge

`default_nettype wire

/* core/hrp_port.sv */
/*
  Host register port: an 8-bit three-state parallel port with chip
  select, read and write strobes and three select lines. Holds a bank of
  eight locations that the host writes and reads back; the device core
  may read them and can override read data through rd_data_i.
  Assumes host pins are synchronous to sys_clk_i and that the testbench
  resolves the bus wire from host_data_bus_oe_n_o.
*/
`default_nettype none

// Functional notes
// - select lines choose register on every access.
// - eight-bit bus, bit 0 least significant.
// - all transfers use the one data bus.
// - chip select low: strobes set bus direction.
// - chip select high: bus released, strobes ignored.
// - read low drives selected register onto bus.
// - read cycle starts on read falling edge.
// - write low accepts bus into selected register.
// - write completes on write rising edge.
module hrp_port #(
  parameter int unsigned NUM_LOC = hrp_pkg::NUM_LOC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Host pins
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [2:0] register_select_lines_i,
  input wire logic [7:0] host_data_bus_i,
  output logic [7:0] host_data_bus_o,
  output logic host_data_bus_oe_n_o,
  // Device side
  input wire logic [7:0] rd_data_i,
  input wire logic rd_data_use_i,
  output logic [2:0] rd_sel_o,
  output logic rd_start_o,
  output logic wr_stb_o,
  output logic [2:0] wr_sel_o,
  output logic [7:0] wr_data_o,
  output logic [NUM_LOC*8-1:0] loc_flat_o
);

  // ---------------------------------------------------------------
  // Input grouping and edge detection
  // ---------------------------------------------------------------
  hrp_pkg::hrp_host_in_type hin;
  hrp_pkg::hrp_host_in_type hin_q;
  hrp_pkg::hrp_wr_type wr_d;
  logic rd_fall;
  logic wr_rise;

  // One register stage keeps data and selects aligned with the edges.
  assign hin = '{cs_n: cs_n_i, rd_n: rd_n_i, wr_n: wr_n_i,
                 sel: register_select_lines_i, data: host_data_bus_i};

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hin_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                 sel: hrp_pkg::SEL_RESET, data: hrp_pkg::DATA_RESET};
    end else begin
      hin_q <= hin;
    end
  end

  hrp_edge u_rd_edge (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .strobe_n_i(hin_q.rd_n),
    .fall_o(rd_fall),
    .rise_o()
  );

  hrp_edge u_wr_edge (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .strobe_n_i(hin_q.wr_n),
    .fall_o(),
    .rise_o(wr_rise)
  );

  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------
  logic rd_active;
  logic rd_begin;
  logic wr_done;

  // Chip select gates everything; a strobe with it high is ignored.
  assign rd_active = ~hin_q.cs_n & ~hin_q.rd_n & hin_q.wr_n;
  assign rd_begin = rd_fall & ~hin_q.cs_n;
  // The write lands on the rising edge, with data seen at that edge.
  // Data is sampled from the pins, since the host still holds it.
  assign wr_done = wr_rise & ~hin_q.cs_n;
  assign wr_d = '{stb: wr_done, sel: hin_q.sel, data: hin_q.data};

  // ---------------------------------------------------------------
  // Location bank
  // ---------------------------------------------------------------
  logic [7:0] loc_q [NUM_LOC];

  for (genvar g = 0; g < NUM_LOC; g++) begin : g_loc
    logic hit;
    assign hit = wr_d.stb && (wr_d.sel == 3'(g));
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        loc_q[g] <= hrp_pkg::LOC_RESET;
      end else if (hit) begin
        loc_q[g] <= wr_d.data;
      end
    end
    assign loc_flat_o[g*8 +: 8] = loc_q[g];
  end

  // ---------------------------------------------------------------
  // Bus drive
  // ---------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [7:0] bus_d;
  logic [7:0] bus_q;
  logic oe_n_q;
  logic rd_start_q;
  logic [2:0] rd_sel_q;
  logic wr_stb_q;
  logic [2:0] wr_sel_q;
  logic [7:0] wr_data_q;

  // The core may supply status for some locations instead of the bank.
  assign rd_mux = rd_data_use_i ? rd_data_i : loc_q[hin_q.sel];
  // Bit order is kept straight through: bit 0 stays bit 0.
  assign bus_d = rd_active ? rd_mux : bus_q;

  // The only path to the host is this one bus and its enable.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus_q <= hrp_pkg::DATA_RESET;
      oe_n_q <= 1'b1;
    end else begin
      bus_q <= bus_d;
      oe_n_q <= ~rd_active;
    end
  end

  // Event outputs to the core, registered.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_start_q <= 1'b0;
      rd_sel_q <= hrp_pkg::SEL_RESET;
      wr_stb_q <= 1'b0;
      wr_sel_q <= hrp_pkg::SEL_RESET;
      wr_data_q <= hrp_pkg::DATA_RESET;
    end else begin
      rd_start_q <= rd_begin;
      rd_sel_q <= hin_q.sel;
      wr_stb_q <= wr_d.stb;
      wr_sel_q <= wr_d.sel;
      wr_data_q <= wr_d.data;
    end
  end

  assign host_data_bus_o = bus_q;
  assign host_data_bus_oe_n_o = oe_n_q;
  assign rd_start_o = rd_start_q;
  assign rd_sel_o = rd_sel_q;
  assign wr_stb_o = wr_stb_q;
  assign wr_sel_o = wr_sel_q;
  assign wr_data_o = wr_data_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_cs_high_release;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    $past(hin_q.cs_n) |-> host_data_bus_oe_n_o;
  endproperty
  a_cs_high_release: assert property (p_cs_high_release)
    else $error("Bus driven while chip select high");

  property p_read_drives;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    rd_active |=> !host_data_bus_oe_n_o;
  endproperty
  a_read_drives: assert property (p_read_drives)
    else $error("Bus not driven during read");

  property p_read_data;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    rd_active |=> host_data_bus_o == ($past(rd_data_use_i) ?
      $past(rd_data_i) : $past(loc_flat_o[hin_q.sel*8 +: 8]));
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("Read data not selected register");

  property p_read_start;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (!hin_q.cs_n && $fell(hin_q.rd_n)) |=> rd_start_o;
  endproperty
  a_read_start: assert property (p_read_start)
    else $error("Read start missing after falling edge");

  property p_write_edge;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (!hin_q.cs_n && $rose(hin_q.wr_n)) |=>
      (wr_stb_o && wr_data_o == $past(hin_q.data));
  endproperty
  a_write_edge: assert property (p_write_edge)
    else $error("Write not completed on rising edge");

  property p_write_store;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    wr_d.stb |=> loc_q[$past(wr_d.sel)] == $past(wr_d.data);
  endproperty
  a_write_store: assert property (p_write_store)
    else $error("Selected location not written");

  property p_no_write_cs_high;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    hin_q.cs_n |=> !wr_stb_o;
  endproperty
  a_no_write_cs_high: assert property (p_no_write_cs_high)
    else $error("Write taken while chip select high");

  property p_idle_release;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (hin_q.rd_n [*2]) |-> host_data_bus_oe_n_o;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("Bus driven without read strobe");

  c_read: cover property (@(posedge sys_clk_i) rd_start_o);
  c_write: cover property (@(posedge sys_clk_i) wr_stb_o);
  c_cs_ignore: cover property (@(posedge sys_clk_i)
    hin_q.cs_n && $fell(hin_q.rd_n));

endmodule : hrp_port

`default_nettype wire

/* verif/hrp_host_model.sv */
/*
  Host processor model: drives chip select, strobes, select lines and
  write data. Assumes the bench resolves the shared data wire.
*/
`default_nettype none

module hrp_host_model (
  // Clock
  input wire logic sys_clk_i,
  // Host pins
  output hrp_pkg::hrp_host_in_type pins_o,
  output logic data_en_o,
  // Wire as seen by the host
  input wire logic [7:0] bus_i,
  input wire logic drv_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // -------------------------------------------------------------
  // Bus cycles
  // -------------------------------------------------------------
  // Idle: deselected, both strobes high, bus released.
  initial begin
    pins_o = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, sel: 3'h0, data: 8'h00};
    data_en_o = 1'b0;
  end

  // One strobe pulse. Write data starts wrong for a cycle, so only the
  // late value may land. Returns {device driving, wire} mid-pulse.
  task automatic cycle(input logic w, input logic cs_n,
    input logic [2:0] s, input logic [7:0] d, output logic [8:0] q);
    @(posedge sys_clk_i);
    pins_o.cs_n <= cs_n;
    pins_o.sel <= s;
    pins_o.data <= ~d;
    data_en_o <= w;
    pins_o.wr_n <= ~w;
    pins_o.rd_n <= w;
    @(posedge sys_clk_i);
    pins_o.data <= d;
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    q = {drv_i, bus_i};
    @(posedge sys_clk_i);
    pins_o.wr_n <= 1'b1;
    pins_o.rd_n <= 1'b1;
    @(posedge sys_clk_i);
    data_en_o <= 1'b0;
    pins_o.cs_n <= 1'b1;
  endtask : cycle
endmodule : hrp_host_model

`default_nettype wire

/* verif/host_register_port_test.sv */
/*
  Self-checking bench for the host register port with a host model.
  Assumes the port and the host model compile before it.
*/
`default_nettype none

module host_register_port_test;
  timeunit 1ns;
  timeprecision 1ps;

  // -------------------------------------------------------------
  // Signals, wire and pulse watchers
  // -------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  hrp_pkg::hrp_host_in_type pins;
  logic host_en, oe_n, rd_start, wr_stb;
  logic rd_use = 1'b0;
  logic [7:0] bus, bus_o, float_q = 8'h5A, wr_data;
  logic [7:0] rd_data = 8'h00;
  logic [2:0] rd_sel, wr_sel;
  logic [63:0] locs;
  logic [7:0] exp_loc [8];
  logic [10:0] last_wr;
  logic [8:0] q;
  logic [31:0] seed = 32'h0000002C;
  int failures = 0, cmp_count = 0, n_wr = 0, n_rd = 0;

  // Clock at 250 MHz.
  always #2 sys_clk = ~sys_clk;

  // Undriven wire shows a pattern that changes each cycle, never 0.
  assign bus = !oe_n ? bus_o : host_en ? pins.data : float_q;
  always @(posedge sys_clk) float_q <= ~float_q;

  // Count the one-cycle pulses and keep the last write event.
  always @(posedge sys_clk) begin
    if (wr_stb === 1'b1) begin
      n_wr++;
      last_wr = {wr_sel, wr_data};
    end
    if (rd_start === 1'b1) n_rd++;
  end

  hrp_port hrp_port_i (.sys_clk_i(sys_clk), .rstn_i(rstn),
    .cs_n_i(pins.cs_n), .rd_n_i(pins.rd_n), .wr_n_i(pins.wr_n),
    .register_select_lines_i(pins.sel), .host_data_bus_i(bus),
    .host_data_bus_o(bus_o), .host_data_bus_oe_n_o(oe_n),
    .rd_data_i(rd_data), .rd_data_use_i(rd_use), .rd_sel_o(rd_sel),
    .rd_start_o(rd_start), .wr_stb_o(wr_stb), .wr_sel_o(wr_sel),
    .wr_data_o(wr_data), .loc_flat_o(locs));
  hrp_host_model hrp_host_model_i (.sys_clk_i(sys_clk), .pins_o(pins),
    .data_en_o(host_en), .bus_i(bus), .drv_i(!oe_n));

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic check(input string what, input logic [63:0] exp,
    input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : check

  task automatic results();
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  // A write, then the event and the bank are compared with the model.
  task automatic wr(input logic cs_n, input logic [2:0] s,
    input logic [7:0] d);
    int n0;
    n0 = n_wr;
    hrp_host_model_i.cycle(1'b1, cs_n, s, d, q);
    repeat (4) @(posedge sys_clk);
    if (!cs_n) exp_loc[s] = d;
    check("write count", 64'(n0 + (cs_n ? 0 : 1)), 64'(n_wr));
    if (!cs_n) check("write event", {s, d}, last_wr);
    check("bank", exp_loc[s], locs[s*8+:8]);
  endtask : wr

  // A read; deselected reads must leave the wire undriven.
  task automatic rd(input logic cs_n, input logic [2:0] s);
    int n0;
    n0 = n_rd;
    hrp_host_model_i.cycle(1'b0, cs_n, s, 8'h00, q);
    if (cs_n) check("driven", 64'h0, q[8]);
    else check("read", {1'b1, rd_use ? rd_data : exp_loc[s]}, q);
    if (!cs_n) check("read select", s, rd_sel);
    repeat (3) @(negedge sys_clk);
    check("read start", 64'(n0 + (cs_n ? 0 : 1)), 64'(n_rd));
    check("released", 64'h1, oe_n);
  endtask : rd

  // -------------------------------------------------------------
  // Sequence and watchdog
  // -------------------------------------------------------------
  initial begin
    for (int i = 0; i < 8; i++) exp_loc[i] = 8'h00;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      wr(1'b0, 3'(i), seed[7:0]);
    end
    for (int i = 0; i < 30; i++) begin
      seed = xs(seed);
      @(posedge sys_clk);
      rd_use <= seed[8];
      rd_data <= seed[23:16];
      if (seed[9]) wr(seed[12], seed[2:0], seed[31:24]);
      else rd(seed[12], seed[2:0]);
    end
    @(posedge sys_clk);
    rd_use <= 1'b0;
    wr(1'b0, 3'h7, 8'hFF);
    wr(1'b0, 3'h0, 8'h01);
    rd(1'b0, 3'h7);
    rd(1'b0, 3'h0);
    results();
  end

  // About 40 transfers of a dozen cycles; far more means a hang.
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    results();
  end
endmodule : host_register_port_test

`default_nettype wire
